/* tsr_sensor_regs.sv */
/*
  Temperature sensor register block behind a two-wire serial slave:
  pointer, temperature, configuration, limit and one-shot registers,
  conversion control, fault queue and overtemperature alert pin.
  Assumes the host makes the serial clock, which stands still between
  frames, and an external wire resolves the open-drain data line.
*/
// Contract
// [RL1] One-shot bit set: stop autonomous conversions, enter shutdown at once.
// [RL2] Pointer write of 0x04 powers up, converts once, powers down.
// [RL3] Host waits 60 ms after a one-shot write before reading.
// [RL4] Reading location 0x04 returns the same value as temperature register.
// [RL5] One-shot write activates alert when result exceeds the limits.
// [RL6] Interrupt mode: any register read deactivates the alert.
// [RL7] Comparator mode: one-shot clears alert once below hysteresis limit.
// [RL8] Bits 4:3 set consecutive-fault count; a good conversion restarts it.
// [RL9] Configuration is 8 bits; temperature and limits are 16 bits.
// [RL10] Temperature is read-only; configuration, limits, one-shot are writable.
// [RL11] Pointer resets to 0x00, selecting the temperature register.
// [RL12] Pointer codes 0 to 4 select temperature, config, hyst, high, one-shot.
// [RL13] Host writes zeros to pointer bits above the low three.
// [RL14] Sixteen-bit reads send the upper byte first, then the lower.
// [RL15] Temperature is two's complement with the top bit as sign.
// [RL16] Config bit layout as fixed; every bit resets to zero.
// [RL17] Config bit 1: zero comparator, one interrupt behaviour.
// [RL18] Config bit 2: zero alert active low, one active high.
// [RL19] Queue codes 00, 01, 10 need one, two, four faults.
// [RL20] Config bit 0 powers down all but the serial interface.
// [RL21] Pointer keeps its value between transactions.
// [RL22] A pointer-only write changes no data register.
`default_nettype none
module tsr_sensor_regs #(
  parameter int unsigned CONV_CYCLES = tsr_pkg::CONV_CYCLES_DEFAULT,
  parameter logic [6:0] DEVICE_ADDR = tsr_pkg::DEVICE_ADDR_DEFAULT
) (
  // System clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Serial link
  input wire logic scl_clk_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Converter
  input wire logic [11:0] adc_code_in,
  output logic converter_power_out,
  // Alert
  output logic overtemp_alert_pin_out
);
  import tsr_pkg::*;

  function automatic logic [2:0] fault_depth(input logic [1:0] code);
    logic [2:0] depth;
    depth = DEPTH_SIX;
    if (code == QUEUE_ONE) begin
      depth = DEPTH_ONE;
    end else if (code == QUEUE_TWO) begin
      depth = DEPTH_TWO;
    end else if (code == QUEUE_FOUR) begin
      depth = DEPTH_FOUR;
    end
    return depth;
  endfunction

  // Reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Start condition detector, clocked by the data line itself
  logic start_tgl;

  always_ff @(negedge sda_in or negedge rst_n) begin
    if (!rst_n) begin
      start_tgl <= 1'b0;
    end else if (scl_clk_in) begin
      start_tgl <= ~start_tgl;
    end
  end

  // Link domain
  tsr_link_state_t link_state;
  logic start_seen;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic is_read;
  logic byte_sel;
  logic [1:0] byte_idx;
  logic [7:0] wr_byte;
  logic [1:0] wr_idx;
  logic wr_tgl;
  logic rd_tgl;
  logic [15:0] rd_word;
  logic [7:0] tx_byte;

  // Read word is quasi-static: the host cannot reach the first data bit
  // until well after the sys side has refreshed it
  assign tx_byte = byte_sel ? rd_word[7:0] : rd_word[15:8];

  always_ff @(posedge scl_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      link_state <= LK_IDLE;
      start_seen <= 1'b0;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      is_read <= 1'b0;
      byte_sel <= 1'b0;
      byte_idx <= BYTE_PTR;
      wr_byte <= 8'h00;
      wr_idx <= BYTE_PTR;
      wr_tgl <= 1'b0;
      rd_tgl <= 1'b0;
    end else if (start_tgl != start_seen) begin
      start_seen <= start_tgl;
      link_state <= LK_ADDR;
      bit_cnt <= 3'h1;
      shift <= {7'h00, sda_in};
    end else begin
      unique case (link_state)
        LK_IDLE: begin
          bit_cnt <= 3'h0;
        end
        LK_ADDR: begin
          shift <= {shift[6:0], sda_in};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == BIT_LAST) begin
            if (shift[6:0] == DEVICE_ADDR) begin
              link_state <= LK_ACK;
              is_read <= sda_in;
              byte_sel <= 1'b0;
              byte_idx <= BYTE_PTR;
              if (sda_in) begin
                rd_tgl <= ~rd_tgl;
              end
            end else begin
              link_state <= LK_IDLE;
            end
          end
        end
        LK_ACK: begin
          bit_cnt <= 3'h0;
          link_state <= is_read ? LK_READ : LK_WRITE;
        end
        LK_WRITE: begin
          shift <= {shift[6:0], sda_in};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == BIT_LAST) begin
            wr_byte <= {shift[6:0], sda_in};
            wr_idx <= byte_idx;
            wr_tgl <= ~wr_tgl;
            if (byte_idx != BYTE_EXTRA) begin
              byte_idx <= byte_idx + 2'h1;
            end
            link_state <= LK_ACK;
          end
        end
        LK_READ: begin
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == BIT_LAST) begin
            link_state <= LK_RACK;
          end
        end
        LK_RACK: begin
          bit_cnt <= 3'h0;
          if (!sda_in) begin
            byte_sel <= ~byte_sel; // [RL14]
            link_state <= LK_READ;
          end else begin
            link_state <= LK_IDLE;
          end
        end
      endcase
    end
  end

  // Data line changes only while the clock is low
  always_ff @(negedge scl_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_out <= 1'b0;
    end else begin
      unique case (link_state)
        LK_ACK: sda_oe_out <= 1'b1;
        LK_READ: sda_oe_out <= ~tx_byte[3'h7 - bit_cnt]; // [RL14]
        default: sda_oe_out <= 1'b0;
      endcase
    end
  end

  assign sda_out = 1'b0;

  // Events into the system domain
  logic wr_pulse;
  logic rd_pulse;

  tsr_tgl_sync u_wr_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .tgl_in(wr_tgl),
    .pulse_out(wr_pulse)
  );

  tsr_tgl_sync u_rd_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .tgl_in(rd_tgl),
    .pulse_out(rd_pulse)
  );

  // Register file
  logic [7:0] pointer;
  logic [7:0] setup_control;
  logic [15:0] hysteresis_limit;
  logic [15:0] high_temp_limit;
  logic [15:0] temperature_result;
  logic [7:0] first_byte;
  logic oneshot_pulse;
  logic [2:0] sel;

  // Only the low three bits decode; the host keeps the rest zero
  assign sel = pointer[2:0]; // [RL12] [RL13]
  assign oneshot_pulse = wr_pulse && (wr_idx == BYTE_PTR) &&
                         (wr_byte[2:0] == PTR_ONESHOT); // [RL2]

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pointer <= PTR_RESET; // [RL11]
    end else if (wr_pulse && (wr_idx == BYTE_PTR)) begin
      pointer <= wr_byte; // [RL21] [RL22]
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      setup_control <= CFG_RESET; // [RL16]
    end else if (wr_pulse && (wr_idx == BYTE_FIRST) && (sel == PTR_CFG)) begin
      setup_control <= wr_byte & CFG_WRITE_MASK; // [RL9] [RL10] [RL16]
    end
  end

  // A 16-bit limit changes only when both bytes arrive, never half-written
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      first_byte <= 8'h00;
      hysteresis_limit <= HYST_RESET;
      high_temp_limit <= HIGH_RESET;
    end else if (wr_pulse) begin
      if (wr_idx == BYTE_FIRST) begin
        first_byte <= wr_byte;
      end else if (wr_idx == BYTE_SECOND) begin
        if (sel == PTR_HYST) begin
          hysteresis_limit <= {first_byte, wr_byte}; // [RL9] [RL10]
        end
        if (sel == PTR_HIGH) begin
          high_temp_limit <= {first_byte, wr_byte}; // [RL9] [RL10]
        end
      end
    end
  end

  // Read word refreshed at each read address; config sits in the upper byte
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_word <= TEMP_RESET;
    end else if (rd_pulse) begin
      unique case (sel)
        PTR_TEMP: rd_word <= temperature_result;
        PTR_CFG: rd_word <= {setup_control, 8'h00};
        PTR_HYST: rd_word <= hysteresis_limit;
        PTR_HIGH: rd_word <= high_temp_limit;
        PTR_ONESHOT: rd_word <= temperature_result; // [RL4]
        default: rd_word <= 16'h0000;
      endcase
    end
  end

  // Conversion control
  logic low_power;
  logic oneshot_run;
  logic conv_busy;
  logic conv_done;
  logic conv_start;
  logic conv_abort;
  logic [15:0] conv_result;

  assign low_power = setup_control[CFG_SHUTDOWN] || setup_control[CFG_ONESHOT]; // [RL1] [RL20]
  // The trigger cycle must not abort, since abort beats start in the sequencer
  assign conv_abort = low_power && !oneshot_run && !oneshot_pulse; // [RL1] [RL20]
  assign conv_start = oneshot_pulse || (!low_power && !conv_busy); // [RL2]

  // A one-shot requested while a conversion runs restarts nothing; it
  // takes over the running conversion as its own
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      oneshot_run <= 1'b0;
    end else if (oneshot_pulse) begin
      oneshot_run <= 1'b1; // [RL2]
    end else if (conv_done) begin
      oneshot_run <= 1'b0; // [RL2]
    end
  end

  tsr_conv #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_conv (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .start_in(conv_start),
    .abort_in(conv_abort),
    .adc_code_in(adc_code_in),
    .busy_out(conv_busy),
    .done_out(conv_done),
    .result_out(conv_result)
  );

  assign converter_power_out = conv_busy;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      temperature_result <= TEMP_RESET;
    end else if (conv_done) begin
      temperature_result <= conv_result; // [RL15]
    end
  end

  // Fault queue and alert
  logic over_limit;
  logic under_hyst;
  logic [2:0] fault_cnt;
  logic queue_met;
  logic alert_active;

  assign over_limit = $signed(conv_result) > $signed(high_temp_limit); // [RL15]
  assign under_hyst = $signed(conv_result) < $signed(hysteresis_limit); // [RL15]
  assign queue_met = conv_done && over_limit &&
    ((fault_cnt + 3'h1) >= fault_depth(setup_control[CFG_QUEUE_HI:CFG_QUEUE_LO])); // [RL8] [RL19]

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fault_cnt <= 3'h0;
    end else if (conv_done) begin
      if (!over_limit) begin
        fault_cnt <= 3'h0; // [RL8]
      end else if (fault_cnt != DEPTH_SIX) begin
        fault_cnt <= fault_cnt + 3'h1; // [RL8]
      end
    end
  end

  // A new fault beats a read clearing in the same cycle
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      alert_active <= 1'b0;
    end else if (queue_met) begin
      alert_active <= 1'b1; // [RL5] [RL8]
    end else if (setup_control[CFG_INT_MODE]) begin
      if (rd_pulse) begin
        alert_active <= 1'b0; // [RL6] [RL17]
      end
    end else if (conv_done && under_hyst) begin
      alert_active <= 1'b0; // [RL7] [RL17]
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_alert_pin_out <= 1'b1;
    end else begin
      overtemp_alert_pin_out <= alert_active ~^ setup_control[CFG_POLARITY]; // [RL18]
    end
  end
endmodule
`default_nettype wire

/* tsr_pkg.sv */
/*
  Shared constants and types of the temperature sensor register block:
  pointer codes, configuration field positions, reset values, fault queue
  encodings, link states and conversion timing.
  Assumes a 50 MHz system clock.
*/
`default_nettype none
package tsr_pkg;
  // Pointer select codes (low three pointer bits)
  localparam logic [2:0] PTR_TEMP = 3'h0;
  localparam logic [2:0] PTR_CFG = 3'h1;
  localparam logic [2:0] PTR_HYST = 3'h2;
  localparam logic [2:0] PTR_HIGH = 3'h3;
  localparam logic [2:0] PTR_ONESHOT = 3'h4;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // Configuration fields
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_INT_MODE = 1;
  localparam int CFG_POLARITY = 2;
  localparam int CFG_QUEUE_LO = 3;
  localparam int CFG_QUEUE_HI = 4;
  localparam int CFG_ONESHOT = 5;
  localparam int CFG_ALERT_EN = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hBF;
  // Data register reset values
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [15:0] HYST_RESET = 16'h4B00;
  localparam logic [15:0] HIGH_RESET = 16'h5000;
  localparam logic [3:0] TEMP_PAD = 4'h0;
  // Fault queue encodings and depths
  localparam logic [1:0] QUEUE_ONE = 2'h0;
  localparam logic [1:0] QUEUE_TWO = 2'h1;
  localparam logic [1:0] QUEUE_FOUR = 2'h2;
  localparam logic [2:0] DEPTH_ONE = 3'h1;
  localparam logic [2:0] DEPTH_TWO = 3'h2;
  localparam logic [2:0] DEPTH_FOUR = 3'h4;
  localparam logic [2:0] DEPTH_SIX = 3'h6;
  // Byte position within a write transaction
  localparam logic [1:0] BYTE_PTR = 2'h0;
  localparam logic [1:0] BYTE_FIRST = 2'h1;
  localparam logic [1:0] BYTE_SECOND = 2'h2;
  localparam logic [1:0] BYTE_EXTRA = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Bus address, value is arbitrary
  localparam logic [6:0] DEVICE_ADDR_DEFAULT = 7'h2A;
  // Conversion timing
  localparam int SYS_CLK_HZ = 50000000;
  localparam int CONV_TIME_MS = 60;
  localparam int CONV_CYCLES_DEFAULT = (SYS_CLK_HZ / 1000) * CONV_TIME_MS;
  typedef enum logic [5:0] {
    LK_IDLE = 6'b000001,
    LK_ADDR = 6'b000010,
    LK_ACK = 6'b000100,
    LK_WRITE = 6'b001000,
    LK_READ = 6'b010000,
    LK_RACK = 6'b100000
  } tsr_link_state_t;
endpackage
`default_nettype wire

/* tsr_tgl_sync.sv */
/*
  Toggle synchroniser: carries an event from another clock domain as a
  toggle and gives a one-cycle pulse in the local domain.
  Assumes toggles are spaced several local clocks apart.
*/
`default_nettype none
module tsr_tgl_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Event
  input wire logic tgl_in,
  output logic pulse_out
);
  logic meta;
  logic sync;
  logic last;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= tgl_in;
      sync <= meta;
      last <= sync;
    end
  end

  assign pulse_out = sync ^ last;
endmodule
`default_nettype wire

/* tsr_conv.sv */
/*
  Conversion sequencer: on start it powers the converter for a fixed
  number of cycles, then latches the converter code as a result.
  Assumes the converter code comes from outside this clock domain.
*/
`default_nettype none
module tsr_conv #(
  parameter int unsigned CONV_CYCLES = tsr_pkg::CONV_CYCLES_DEFAULT
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [11:0] adc_code_in,
  // Result
  output logic busy_out,
  output logic done_out,
  output logic [15:0] result_out
);
  import tsr_pkg::*;
  logic [11:0] code_meta;
  logic [11:0] code_sync;
  logic [31:0] count;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      code_meta <= 12'h000;
      code_sync <= 12'h000;
    end else begin
      code_meta <= adc_code_in;
      code_sync <= code_meta;
    end
  end

  // Abort beats start so shutdown takes hold at once
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
      count <= 32'h0000_0000;
    end else if (abort_in) begin
      busy_out <= 1'b0;
      count <= 32'h0000_0000;
    end else if (busy_out) begin
      count <= count + 32'h0000_0001;
      if (count == CONV_CYCLES - 1) begin
        busy_out <= 1'b0;
      end
    end else if (start_in) begin
      busy_out <= 1'b1;
      count <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_out <= 1'b0;
      result_out <= TEMP_RESET;
    end else begin
      done_out <= busy_out && !abort_in && (count == CONV_CYCLES - 1);
      if (busy_out && !abort_in && (count == CONV_CYCLES - 1)) begin
        result_out <= {code_sync, TEMP_PAD};
      end
    end
  end
endmodule
`default_nettype wire

/* tsr_sensor_regs_monitor.sv */
/* Port checker for the sensor register block, bound after the module.
   Assumes the serial clock rests high between frames. */
`default_nettype none
module tsr_sensor_regs_monitor #(
  parameter int unsigned CONV_CYCLES = tsr_pkg::CONV_CYCLES_DEFAULT
) (
  // Clocks and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic scl_clk_in,
  // Pins
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [11:0] adc_code_in,
  input wire logic converter_power_out,
  input wire logic overtemp_alert_pin_out
);
  int unsigned on_cnt;
  int unsigned fall_age;
  int unsigned scl_age;
  logic scl_q;
  logic pwr_q;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Ages saturate so a long idle span never wraps them
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      on_cnt <= 0;
      fall_age <= 0;
      scl_age <= 0;
      scl_q <= 1'b1;
      pwr_q <= 1'b0;
    end else begin
      on_cnt <= converter_power_out ? on_cnt + 1 : 0;
      fall_age <= (pwr_q && !converter_power_out) ? 0 : (fall_age < 999 ? fall_age + 1 : 999);
      scl_age <= (scl_clk_in != scl_q) ? 0 : (scl_age < 999 ? scl_age + 1 : 999);
      scl_q <= scl_clk_in;
      pwr_q <= converter_power_out;
    end
  end
  a_conv_length: assert property (converter_power_out |-> on_cnt < CONV_CYCLES)
    else $error("conversion ran past its cycle count");
  a_alert_cause: assert property (
    $changed(overtemp_alert_pin_out) |-> (fall_age < 8 || scl_age < 64))
    else $error("alert pin moved with no conversion end or link traffic");
  a_open_drain: assert property (!sda_out)
    else $error("data line driven high");
  a_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_clk_in)
    else $error("data drive changed while clock high");
  a_oe_released: assert property (scl_age > 16 |-> !sda_oe_out)
    else $error("data line held outside a frame");
  a_reset_pin_idle: assert property ($rose(reset_n_in) |-> overtemp_alert_pin_out [*3])
    else $error("alert pin not idle high after reset");
  a_reset_powers: assert property ($rose(reset_n_in) |-> ##[1:8] converter_power_out)
    else $error("no conversion started after reset");
  a_reset_quiet: assert property ($rose(reset_n_in) |-> !sda_oe_out ##1 !sda_oe_out)
    else $error("link drives data right after reset");
endmodule
bind tsr_sensor_regs tsr_sensor_regs_monitor #(.CONV_CYCLES(CONV_CYCLES))
  u_tsr_sensor_regs_monitor (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .scl_clk_in(scl_clk_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .adc_code_in(adc_code_in), .converter_power_out(converter_power_out),
  .overtemp_alert_pin_out(overtemp_alert_pin_out));
`default_nettype wire

/* tsr_host.sv */
/* Host model on the two-wire link: start, stop and byte transfers.
   Assumes a pull-up on the data wire outside this model. */
`default_nettype none
module tsr_host (
  // Link
  output logic scl_out,
  output logic sda_pull_out,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quarter of the 125 ns serial clock
  localparam realtime Q = 31.25;
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  // Data moves only while the clock is low, so no false start is seen
  task automatic bit_io(input logic b, output logic s);
    sda_pull_out = ~b;
    #Q scl_out = 1'b1;
    #Q s = sda_in;
    #Q scl_out = 1'b0;
    #Q;
  endtask
  task automatic start();
    sda_pull_out = 1'b1;
    #Q scl_out = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_pull_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q sda_pull_out = 1'b0;
    #(2 * Q);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, ack);
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
endmodule
`default_nettype wire

/* tsr_sensor_regs_test.sv */
/* Self-checking bench for the sensor register block with a host model.
   Assumes a short conversion count so one-shot runs stay brief. */
`default_nettype none
module tsr_sensor_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tsr_pkg::*;
  localparam int unsigned CONV = 50;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [11:0] adc_code_in = 12'hE70;
  logic scl_clk_in;
  logic host_pull;
  logic sda_out;
  logic sda_oe_out;
  logic converter_power_out;
  logic overtemp_alert_pin_out;
  wire logic sda_in = ~(host_pull | (sda_oe_out & ~sda_out));
  int fails = 0;
  int checks_done = 0;
  int fq = 0;
  int dep[4] = '{1, 2, 4, 6};
  logic [15:0] rst_tbl[4] = '{16'h0000, 16'h0000, 16'h4B00, 16'h5000};
  logic al = 1'b0;
  logic [7:0] m_cfg = 8'h00;
  logic [15:0] m_hyst = 16'h4B00;
  logic [15:0] m_high = 16'h5000;
  logic [15:0] m_temp;
  logic [15:0] temps[$];
  logic [15:0] v;
  logic [31:0] r;

  always #10 sys_clk_in = ~sys_clk_in;

  tsr_sensor_regs #(.CONV_CYCLES(CONV)) u_tsr_sensor_regs (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .scl_clk_in(scl_clk_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .adc_code_in(adc_code_in), .converter_power_out(converter_power_out),
    .overtemp_alert_pin_out(overtemp_alert_pin_out));
  tsr_host u_tsr_host (.scl_out(scl_clk_in), .sda_pull_out(host_pull), .sda_in(sda_in));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #2;
  endtask
  task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d);
    logic a;
    u_tsr_host.start();
    u_tsr_host.send_byte({DEVICE_ADDR_DEFAULT, 1'b0}, a);
    check({15'h0, a}, 16'h0000);
    u_tsr_host.send_byte(p, a);
    for (int i = n; i > 0; i--) u_tsr_host.send_byte(d[8*i-1 -: 8], a);
    u_tsr_host.stop();
    tick(1);
    case (p[2:0])
      PTR_CFG: if (n == 1) m_cfg = d[7:0] & 8'hBF;
      PTR_HYST: if (n == 2) m_hyst = d;
      PTR_HIGH: if (n == 2) m_high = d;
      default: ;
    endcase
  endtask
  task automatic rd(output logic [15:0] val);
    logic a;
    u_tsr_host.start();
    u_tsr_host.send_byte({DEVICE_ADDR_DEFAULT, 1'b1}, a);
    u_tsr_host.get_byte(1'b0, val[15:8]);
    u_tsr_host.get_byte(1'b1, val[7:0]);
    u_tsr_host.stop();
    tick(1);
    if (m_cfg[CFG_INT_MODE]) al = 1'b0;
  endtask
  // Pointer bits above the low three stay zero in every caller
  task automatic peek(input logic [7:0] p, output logic [15:0] val);
    wr(p, 0, 16'h0000);
    rd(val);
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      tick(1);
      check({15'h0, converter_power_out}, 16'h0000);
    end
  endtask
  task automatic pin_chk();
    check({15'h0, overtemp_alert_pin_out}, {15'h0, al ~^ m_cfg[CFG_POLARITY]});
  endtask
  task automatic shot(input logic [11:0] t);
    adc_code_in = t;
    // Lets the code pass the two-flop synchroniser before the trigger
    tick(4);
    wr({5'h00, PTR_ONESHOT}, 0, 16'h0000);
    check({15'h0, converter_power_out}, 16'h0001);
    tick(CONV + 10);
    check({15'h0, converter_power_out}, 16'h0000);
    m_temp = {t, 4'h0};
    temps.push_back(m_temp);
    if ($signed(m_temp) > $signed(m_high)) begin
      fq++;
      if (fq >= dep[m_cfg[4:3]]) al = 1'b1;
    end else begin
      fq = 0;
      if (!m_cfg[CFG_INT_MODE] && $signed(m_temp) < $signed(m_hyst)) al = 1'b0;
    end
    pin_chk();
  endtask
  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    fails++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h20D13866));
    tick(2);
    reset_n_in = 1'b1;
    tick(3 * CONV);
    rd(v);
    check(v, 16'hE700);
    for (int i = 1; i < 4; i++) begin
      peek(i[7:0], v);
      check(v, rst_tbl[i]);
    end
    rd(v);
    check(v, 16'h5000);
    repeat (2) begin
      r = $urandom;
      wr(8'h02, 2, r[15:0]);
      wr(8'h03, 2, r[31:16]);
      wr(8'h01, 1, {8'h00, r[7:0]});
      peek(8'h01, v);
      check(v, {m_cfg, 8'h00});
      peek(8'h02, v);
      check(v, m_hyst);
      peek(8'h03, v);
      check(v, m_high);
    end
    wr(8'h00, 2, 16'h1234);
    peek(8'h00, v);
    check(v, 16'hE700);
    wr(8'h02, 2, 16'h4B00);
    wr(8'h03, 2, 16'h5000);
    wr(8'h01, 1, 16'h0001);
    tick(5);
    quiet(2 * CONV);
    peek(8'h01, v);
    check(v, 16'h0100);
    wr(8'h01, 1, 16'h0000);
    repeat (20) if (converter_power_out !== 1'b1) tick(1);
    check({15'h0, converter_power_out}, 16'h0001);
    wr(8'h01, 1, 16'h0020);
    tick(3);
    quiet(2 * CONV);
    shot(12'h190);
    rd(v);
    check(v, temps[$]);
    peek(8'h00, v);
    check(v, 16'h1900);
    shot(12'h600);
    shot(12'h4C0);
    shot(12'h400);
    wr(8'h01, 1, 16'h0026);
    pin_chk();
    shot(12'h600);
    rd(v);
    check(v, temps[$]);
    pin_chk();
    // Queue code 11 is a local choice of six faults; it is exercised too
    for (int q = 0; q < 4; q++) begin
      wr(8'h01, 1, {11'h001, q[1:0], 3'h0});
      shot(12'h400);
      shot(12'h600);
      shot(12'h400);
      repeat (dep[q]) shot(12'h600);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
